// ---- scsi_core_status_registers_bench.sv ----
// Self-checking bench of the status register bank against a reference model.
`timescale 1ns/1ps
module scsi_core_status_registers_bench;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic        scsi_rst, block_move, mm_move, cable_sense_pin, stall, bsy_drive, connected;
  logic [7:0]  paddr, b;
  logic [31:0] pwdata, prdata, rd, dsa_out, m;
  logic [4:0]  fifo_count;
  logic [1:0]  dma_wr, dma_rd, valid, take, cap;
  logic [15:0] dma_wdata, dout, din, in_data;
  logic [2:0]  ph_l, ph;
  logic        req, sdp_lo, sdp_hi, bus_free, sel_other, arb_win;
  logic        ol[2], ob[2], il[2], pl[2];
  logic        arbitration_in_progress, arbitration_lost, arbitration_won, last_disconnect, sw, connected_flag;
  int          n_errors, n_checks;

  scsr_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .scsi_rst(scsi_rst), .scsi_req(req), .scsi_msg(ph_l[2]),
    .scsi_cd(ph_l[1]), .scsi_io(ph_l[0]), .scsi_sdp_lo(sdp_lo), .scsi_sdp_hi(sdp_hi),
    .bus_free(bus_free), .sel_other(sel_other), .arb_win(arb_win), .selected_in(1'b0),
    .block_move(block_move), .mm_move(mm_move), .differential_sense_pin(cable_sense_pin),
    .fifo_count(fifo_count), .dma_wr(dma_wr), .dma_wdata(dma_wdata), .dma_rd(dma_rd),
    .in_capture(cap), .scsi_din(din), .bus_take(take), .scsi_dout(dout),
    .scsi_dout_valid(valid), .in_data(in_data), .bsy_drive(bsy_drive),
    .connected(connected), .dsa_out(dsa_out));

  scsr_scsi_peer peer (.pclk(pclk), .stall(stall), .scsi_dout(dout), .scsi_dout_valid(valid),
    .scsi_req(req), .phase_lines(ph_l), .sdp_lo(sdp_lo), .sdp_hi(sdp_hi),
    .bus_free(bus_free), .sel_other(sel_other), .arb_win(arb_win), .bus_take(take),
    .in_capture(cap), .scsi_din(din));

  // ---------------------------------------------------------------
  // Bus cycles and comparisons
  // ---------------------------------------------------------------
  task automatic complete_run();
    if (n_errors == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("MISMATCH %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // The answer is sampled at the rising edge, before the slave's flops move on.
    for (n = 0; n < 16; n++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    if (n == 16)
    begin
      n_errors++;
      complete_run();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic check_regs();
    apb(1'b0, 8'h34, 32'h0);
    chk(rd, {24'h0, il[0], ob[0], ol[0], arbitration_in_progress, arbitration_lost, arbitration_won, scsi_rst | sw, sdp_lo}, "stat0");
    apb(1'b0, 8'h38, 32'h0);
    chk(rd, {24'h0, fifo_count[3:0], pl[0], ph}, "stat1");
    apb(1'b0, 8'h3c, 32'h0);
    chk(rd, {24'h0, il[1], ob[1], ol[1], fifo_count[4], pl[1], cable_sense_pin, last_disconnect, sdp_hi}, "stat2");
    chk(32'(connected), 32'(connected_flag), "connected");
  endtask

  task automatic wr_lane(input int k, input logic [7:0] v);
    @(posedge pclk);
    dma_wr[k] <= 1'b1;
    dma_wdata[8*k +: 8] <= v;
    @(posedge pclk);
    dma_wr <= 2'b00;
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  initial
  begin
    repeat (100000) @(posedge pclk);
    n_errors++;
    complete_run();
  end

  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata, scsi_rst, block_move, mm_move} = '0;
    {cable_sense_pin, stall, fifo_count, dma_wr, dma_wdata, dma_rd, ph, arbitration_in_progress, arbitration_lost, arbitration_won, sw, connected_flag} = '0;
    ol = '{0, 0};
    ob = '{0, 0};
    il = '{0, 0};
    pl = '{0, 0};
    last_disconnect = 1'b1;
    n_errors = 0;
    n_checks = 0;
    void'($urandom(8));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    check_regs();
    apb(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0, "base reset");
    foreach (paddr[i])
      if (i < 2)
      begin
        apb(1'b0, i ? 8'h35 : 8'h44, 32'h0);
        chk(32'(er), 32'h1, "unmapped error");
        chk(rd, 32'h0, "unmapped data");
      end
    for (int i = 0; i < 6; i++)
    begin
      @(posedge pclk);
      fifo_count <= (i == 0) ? 5'd16 : 5'($urandom_range(16));
      scsi_rst <= 1'($urandom);
      cable_sense_pin <= 1'($urandom);
      peer.sdp_lo <= 1'($urandom);
      peer.sdp_hi <= 1'($urandom);
      check_regs();
    end
    scsi_rst <= 1'b0;
    apb(1'b1, 8'h80, 32'h40);
    sw = 1'b1;
    check_regs();
    apb(1'b1, 8'h80, 32'h0);
    sw = 1'b0;
    for (int a = 0; a < 3; a++)
      apb(1'b1, 8'(8'h34 + 4 * a), 32'hffff_ffff);
    check_regs();
    m = $urandom;
    apb(1'b1, 8'h40, m);
    @(posedge pclk);
    mm_move <= 1'b1;
    apb(1'b1, 8'h40, ~m);
    @(posedge pclk);
    mm_move <= 1'b0;
    apb(1'b0, 8'h40, 32'h0);
    chk(rd, m, "base restored");
    chk(dsa_out, m, "base out");
    for (int p = 0; p < 8; p++)
    begin
      peer.pulse_phase(3'(p));
      ph = 3'(p);
      check_regs();
    end
    for (int md = 0; md < 3; md++)
    begin
      apb(1'b1, 8'h80, 32'h0);
      apb(1'b1, 8'h80, md == 2 ? 32'h2 : 32'h3);
      peer.free_bus();
      {arbitration_in_progress, arbitration_lost, arbitration_won, connected_flag, last_disconnect} = 5'b10001;
      check_regs();
      chk(32'(bsy_drive), 32'h1, "bsy");
      peer.contend(md == 1);
      {arbitration_in_progress, arbitration_lost, arbitration_won, connected_flag} = {1'b0, md == 1, md == 0, md != 1};
      check_regs();
      if (md == 0)
      begin
        @(posedge pclk);
        block_move <= 1'b1;
        @(posedge pclk);
        block_move <= 1'b0;
        last_disconnect = 1'b0;
        check_regs();
      end
    end
    apb(1'b1, 8'h80, 32'h0);
    peer.free_bus();
    {connected_flag, last_disconnect} = 2'b01;
    stall <= 1'b1;
    b = 8'($urandom);
    wr_lane(0, b);
    wr_lane(0, ~b);
    ol[0] = 1'b1;
    check_regs();
    stall <= 1'b0;
    repeat (4) @(posedge pclk);
    ol[0] = 1'b0;
    check_regs();
    chk(32'(peer.got.size()), 32'h1, "async count");
    chk(32'(peer.got.pop_front()), {23'h0, 1'b0, b}, "async byte");
    apb(1'b1, 8'h80, 32'h4);
    stall <= 1'b1;
    wr_lane(1, b);
    wr_lane(1, ~b);
    {ob[1], ol[1]} = 2'b11;
    check_regs();
    stall <= 1'b0;
    repeat (8) @(posedge pclk);
    {ob[1], ol[1]} = 2'b00;
    check_regs();
    chk(32'(peer.got.pop_front()), {23'h0, 1'b1, b}, "sync first");
    chk(32'(peer.got.pop_front()), {23'h0, 1'b1, ~b}, "sync second");
    apb(1'b1, 8'h80, 32'h0);
    for (int k = 0; k < 2; k++)
    begin
      peer.capture(k, b, 1'b1);
      il[k] = 1'b1;
      pl[k] = 1'b1;
      peer.sdp_lo <= 1'b0;
      peer.sdp_hi <= 1'b0;
      check_regs();
      chk(32'(in_data[8*k +: 8]), 32'(b), "in byte");
      @(posedge pclk);
      dma_rd[k] <= 1'b1;
      @(posedge pclk);
      dma_rd <= 2'b00;
      il[k] = 1'b0;
    end
    apb(1'b1, 8'h80, 32'h4);
    peer.capture(0, ~b, 1'b0);
    peer.sdp_lo <= 1'b1;
    check_regs();
    complete_run();
  end
endmodule // scsi_core_status_registers_bench

// ---- scsr_arb.sv ----
// Arbitration progress tracker with in-progress, won and lost flags.
`timescale 1ns/1ps
module scsr_arb
  import scsr_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic arb_go,
  input  wire logic full_arb_mode,
  input  wire logic bus_free,
  input  wire logic sel_other,
  input  wire logic arb_win,
  output scsr_arb_t arb
);
  scsr_arb_t nxt;

  always_comb
  begin
    nxt = arb;
    case (arb.st)
      ARB_IDLE:
        if (arb_go && bus_free)
        begin
          nxt.st  = ARB_RUN;
          nxt.arbitration_lost = 1'b0;
          nxt.arbitration_won = 1'b0;
        end
      ARB_RUN:
        if (sel_other)
        begin
          nxt.st  = ARB_LOST;
          nxt.arbitration_lost = 1'b1;
        end
        else if (arb_win)
        begin
          nxt.st  = ARB_WON;
          nxt.arbitration_won = full_arb_mode;
        end
      ARB_WON, ARB_LOST:
        if (!arb_go)
          nxt.st = ARB_IDLE;
      default:
        nxt.st = ARB_IDLE;
    endcase
    nxt.arbitration_in_progress   = (nxt.st == ARB_RUN);
    nxt.drive = (nxt.st == ARB_RUN) || (nxt.st == ARB_WON);
  end

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      arb <= '0;
    else
      arb <= nxt;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  aip_start_a: assert property (arb.st == ARB_IDLE && arb_go && bus_free |=> arb.arbitration_in_progress && arb.drive)
    else $error("arbitration in progress not shown");
  loa_set_a: assert property (arb.arbitration_in_progress && sel_other |=> arb.arbitration_lost && !arb.arbitration_in_progress && !arb.arbitration_won)
    else $error("lost arbitration not flagged");
  woa_mode_a: assert property (arb.arbitration_in_progress && !sel_other && arb_win |=> arb.arbitration_won == $past(full_arb_mode))
    else $error("won arbitration flag disagrees with mode");
endmodule // scsr_arb

// ---- scsr_lane.sv ----
// One byte lane: output latch, hidden output buffer and input latch with flags.
`timescale 1ns/1ps
module scsr_lane
  import scsr_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       sync_mode,
  input  wire logic       host_wr,
  input  wire logic [7:0] host_data,
  input  wire logic       bus_take,
  input  wire logic       in_capture,
  input  wire logic [7:0] in_byte,
  input  wire logic       in_parity,
  input  wire logic       dma_rd,
  output scsr_lane_t      lane
);
  scsr_lane_t nxt;

  always_comb
  begin
    nxt = lane;
    if (sync_mode)
    begin
      if (bus_take)
        nxt.ob_full = 1'b0;
      if (lane.ol_full && !nxt.ob_full)
      begin
        nxt.ob_data = lane.ol_data;
        nxt.ob_full = 1'b1;
        nxt.ol_full = 1'b0;
      end
    end
    else if (bus_take)
      nxt.ol_full = 1'b0;
    if (host_wr && !lane.ol_full)
    begin
      nxt.ol_data = host_data;
      nxt.ol_full = 1'b1;
    end
    if (dma_rd)
      nxt.il_full = 1'b0;
    if (in_capture && !sync_mode)
    begin
      nxt.il_data = in_byte;
      nxt.il_full = 1'b1;
      nxt.par     = in_parity;
    end
    nxt.dout = sync_mode ? nxt.ob_data : nxt.ol_data;
    nxt.dval = sync_mode ? nxt.ob_full : nxt.ol_full;
  end

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      lane <= '0;
    else
      lane <= nxt;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  olf_set_a: assert property (host_wr && !lane.ol_full |=> lane.ol_full)
    else $error("output latch flag not set after write");
  orf_fill_a: assert property (sync_mode && lane.ol_full && !lane.ob_full |=> lane.ob_full)
    else $error("hidden buffer flag not set after transfer");
  async_bypass_a: assert property (!sync_mode && !lane.ob_full |=> !lane.ob_full)
    else $error("hidden buffer used in asynchronous send");
  ilf_set_a: assert property (in_capture && !sync_mode |=> lane.il_full)
    else $error("input latch flag not set after capture");
  par_hold_a: assert property (!(in_capture && !sync_mode) |=> $stable(lane.par))
    else $error("latched parity changed without capture");
endmodule // scsr_lane

// ---- scsr_params.svh ----
// Register indices, reset values and control field positions of the status bank.
`ifndef SCSR_PARAMS_SVH
`define SCSR_PARAMS_SVH
`define SCSR_IDX_STAT_ARB   6'h0d
`define SCSR_IDX_STAT_FIFO  6'h0e
`define SCSR_IDX_STAT_UPPER 6'h0f
`define SCSR_IDX_DSA        6'h10
`define SCSR_IDX_CTRL       6'h20
`define SCSR_CTRL_RST       8'h00
`define SCSR_DSA_RST        32'h0000_0000
`define SCSR_LAST_DISCONNECT_RST       1'b1
`define SCSR_CTRL_MASK      8'h47
`define SCSR_CTRL_FULL_ARB  0
`define SCSR_CTRL_ARB_GO    1
`define SCSR_CTRL_SYNC      2
`define SCSR_CTRL_SW_RST    6
`endif

// ---- scsr_pkg.sv ----
// Types shared by the status register bank modules.
package scsr_pkg;
  typedef enum logic [1:0] {ARB_IDLE, ARB_RUN, ARB_WON, ARB_LOST} scsr_arb_state_t;

  typedef struct packed {
    scsr_arb_state_t st;
    logic            arbitration_in_progress;
    logic            arbitration_lost;
    logic            arbitration_won;
    logic            drive;
  } scsr_arb_t;

  typedef struct packed {
    logic       ol_full;
    logic       ob_full;
    logic       il_full;
    logic       par;
    logic [7:0] ol_data;
    logic [7:0] ob_data;
    logic [7:0] il_data;
    logic [7:0] dout;
    logic       dval;
  } scsr_lane_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [7:0]  ctrl;
    logic [31:0] data_structure_base;
    logic [31:0] dsa_shadow;
    logic        move_d;
    logic        req_d;
    logic [2:0]  phase;
    logic        connected_flag;
    logic        last_disconnect;
  } scsr_top_t;
endpackage

// ---- scsr_scsi_peer.sv ----
// Behavioural model of the other parties and lines on the SCSI bus.
`timescale 1ns/1ps
module scsr_scsi_peer
(
  input  wire logic        pclk,
  input  wire logic        stall,
  input  wire logic [15:0] scsi_dout,
  input  wire logic [1:0]  scsi_dout_valid,
  output logic             scsi_req,
  output logic [2:0]       phase_lines,
  output logic             sdp_lo,
  output logic             sdp_hi,
  output logic             bus_free,
  output logic             sel_other,
  output logic             arb_win,
  output logic [1:0]       bus_take,
  output logic [1:0]       in_capture,
  output logic [15:0]      scsi_din
);
  logic [8:0] got[$];

  initial
  begin
    {scsi_req, phase_lines, sdp_lo, sdp_hi, bus_free, sel_other, arb_win} = '0;
    {bus_take, in_capture, scsi_din} = '0;
  end

  // ---------------------------------------------------------------
  // Bus phases, arbitration and data
  // ---------------------------------------------------------------
  task automatic pulse_phase(input logic [2:0] p);
    @(posedge pclk);
    phase_lines <= p;
    @(posedge pclk);
    scsi_req <= 1'b1;
    @(posedge pclk);
    scsi_req <= 1'b0;
    phase_lines <= ~p;
  endtask

  task automatic free_bus();
    @(posedge pclk);
    bus_free <= 1'b1;
    @(posedge pclk);
    bus_free <= 1'b0;
  endtask

  // A losing contest raises select, a winning one lets our own ID win.
  task automatic contend(input logic lose);
    @(posedge pclk);
    sel_other <= lose;
    arb_win <= !lose;
    @(posedge pclk);
    sel_other <= 1'b0;
    arb_win <= 1'b0;
  endtask

  task automatic capture(input int k, input logic [7:0] b, input logic par);
    @(posedge pclk);
    scsi_din[8*k +: 8] <= b;
    in_capture[k] <= 1'b1;
    if (k == 0)
      sdp_lo <= par;
    else
      sdp_hi <= par;
    @(posedge pclk);
    in_capture <= 2'b00;
    scsi_din <= ~scsi_din;
  endtask

  // Takes each presented byte once, unless the bench stalls the bus.
  always @(posedge pclk)
  begin
    for (int k = 0; k < 2; k++)
    begin
      bus_take[k] <= !stall && scsi_dout_valid[k] && !bus_take[k];
      if (!stall && scsi_dout_valid[k] && !bus_take[k])
        got.push_back({k[0], scsi_dout[8*k +: 8]});
    end
  end
endmodule // scsr_scsi_peer

// ---- scsr_top.sv ----
// Status register bank of the SCSI core with its APB slave.
`timescale 1ns/1ps
`include "scsr_params.svh"

// Contract
// - Low hidden-buffer full flag is set while its low byte holds data; readable in the arbitration status register.
// - Synchronous sends go latch, hidden buffer, bus; asynchronous sends skip the buffer.
// - Low output-latch full flag is set while the latch low byte holds data.
// - Arbitration-in-progress reads 1 after bus free, BSY driven and own ID placed.
// - Lost-arbitration flag sets when another device asserts SEL during arbitration.
// - Won-arbitration flag sets on winning, only in full arbitration with selection mode.
// - Reset status bit shows live SCSI RST together with the software reset bit.
// - A status bit shows the live active-high low-byte parity line.
// - Five-bit live count of the synchronous FIFO, 0 to 16, MSB in upper register.
// - Latched low parity updates only when a new low byte is captured.
// - MSG, C/D and I/O are captured on each asserting REQ edge.
// - High input-latch full flag; only asynchronous data passes that latch.
// - High hidden-buffer full flag is set while its high byte holds data.
// - High output-latch full flag is set while the latch high byte holds data.
// - A bit shows the parity captured with the high input-latch byte.
// - Cable sense reads 0 for a differential cable, 1 for single-ended.
// - Last-disconnect sets while not connected, clears on block move when connected; resets 1.
// - A status bit shows the live active-high high-byte parity line.
// - A 32-bit base register, shadowed across memory-to-memory moves.
// - Low input-latch full flag is set while the latch low byte holds data.
// - Connected flag sets on winning arbitration or being selected, clears when the bus goes free.
module scsr_top
  import scsr_pkg::*;
#(
  parameter int LANES = 2
)
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output wire logic [31:0]       prdata,
  output wire logic              pready,
  output wire logic              pslverr,
  input  wire logic              scsi_rst,
  input  wire logic              scsi_req,
  input  wire logic              scsi_msg,
  input  wire logic              scsi_cd,
  input  wire logic              scsi_io,
  input  wire logic              scsi_sdp_lo,
  input  wire logic              scsi_sdp_hi,
  input  wire logic              bus_free,
  input  wire logic              sel_other,
  input  wire logic              arb_win,
  input  wire logic              selected_in,
  input  wire logic              block_move,
  input  wire logic              mm_move,
  input  wire logic              differential_sense_pin,
  input  wire logic [4:0]        fifo_count,
  input  wire logic [LANES-1:0]  dma_wr,
  input  wire logic [8*LANES-1:0] dma_wdata,
  input  wire logic [LANES-1:0]  dma_rd,
  input  wire logic [LANES-1:0]  in_capture,
  input  wire logic [8*LANES-1:0] scsi_din,
  input  wire logic [LANES-1:0]  bus_take,
  output wire logic [8*LANES-1:0] scsi_dout,
  output wire logic [LANES-1:0]  scsi_dout_valid,
  output wire logic [8*LANES-1:0] in_data,
  output wire logic              bsy_drive,
  output wire logic              connected,
  output wire logic [31:0]       dsa_out
);
  // ----------------------------------------------------------------
  // Sub-blocks
  // ----------------------------------------------------------------
  scsr_top_t  r;
  scsr_top_t  nxt;
  scsr_arb_t  arb;
  scsr_lane_t lane_q [LANES];
  logic [1:0] par_in;

  assign par_in = {scsi_sdp_hi, scsi_sdp_lo};

  scsr_arb u_arb (
    .pclk          (pclk),
    .presetn       (presetn),
    .arb_go        (r.ctrl[`SCSR_CTRL_ARB_GO]),
    .full_arb_mode (r.ctrl[`SCSR_CTRL_FULL_ARB]),
    .bus_free      (bus_free),
    .sel_other     (sel_other),
    .arb_win       (arb_win),
    .arb           (arb)
  );

  genvar g;
  for (g = 0; g < LANES; g++)
  begin : g_lane
    scsr_lane u_lane (
      .pclk       (pclk),
      .presetn    (presetn),
      .sync_mode  (r.ctrl[`SCSR_CTRL_SYNC]),
      .host_wr    (dma_wr[g]),
      .host_data  (dma_wdata[8*g +: 8]),
      .bus_take   (bus_take[g]),
      .in_capture (in_capture[g]),
      .in_byte    (scsi_din[8*g +: 8]),
      .in_parity  (par_in[g % 2]),
      .dma_rd     (dma_rd[g]),
      .lane       (lane_q[g])
    );
    assign scsi_dout[8*g +: 8] = lane_q[g].dout;
    assign scsi_dout_valid[g]  = lane_q[g].dval;
    assign in_data[8*g +: 8]   = lane_q[g].il_data;
  end

  // ----------------------------------------------------------------
  // Register bank
  // ----------------------------------------------------------------
  logic [5:0] idx;
  logic       aligned;
  logic       setup;
  logic       access;
  logic       hit;
  logic [7:0] stat_arb;
  logic [7:0] stat_fifo;
  logic [7:0] stat_upper;

  assign idx     = paddr[7:2];
  assign aligned = (paddr[1:0] == 2'b00);
  assign setup   = psel && !penable;
  assign access  = psel && penable && r.pready;

  always_comb
  begin
    hit = aligned && (idx == `SCSR_IDX_STAT_ARB || idx == `SCSR_IDX_STAT_FIFO ||
                      idx == `SCSR_IDX_STAT_UPPER || idx == `SCSR_IDX_DSA ||
                      idx == `SCSR_IDX_CTRL);
  end

  // Status views; the upper lane reads as empty when only one lane is built.
  always_comb
  begin
    stat_arb   = {lane_q[0].il_full,
                  lane_q[0].ob_full,
                  lane_q[0].ol_full,
                  arb.arbitration_in_progress,
                  arb.arbitration_lost,
                  arb.arbitration_won,
                  scsi_rst | r.ctrl[`SCSR_CTRL_SW_RST],
                  scsi_sdp_lo};
    stat_fifo  = {fifo_count[3:0],
                  lane_q[0].par,
                  r.phase};
    stat_upper = {lane_q[LANES-1].il_full & (LANES > 1),
                  lane_q[LANES-1].ob_full & (LANES > 1),
                  lane_q[LANES-1].ol_full & (LANES > 1),
                  fifo_count[4],
                  lane_q[LANES-1].par & (LANES > 1),
                  differential_sense_pin,
                  r.last_disconnect,
                  scsi_sdp_hi};
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt = r;
    nxt.pready  = setup;
    nxt.pslverr = setup && !hit;
    if (setup)
    begin
      nxt.prdata = 32'h0000_0000;
      if (aligned && !pwrite)
      begin
        case (idx)
          `SCSR_IDX_STAT_ARB:   nxt.prdata = {24'h00_0000, stat_arb};
          `SCSR_IDX_STAT_FIFO:  nxt.prdata = {24'h00_0000, stat_fifo};
          `SCSR_IDX_STAT_UPPER: nxt.prdata = {24'h00_0000, stat_upper};
          `SCSR_IDX_DSA:        nxt.prdata = r.data_structure_base;
          `SCSR_IDX_CTRL:       nxt.prdata = {24'h00_0000, r.ctrl};
          default:              nxt.prdata = 32'h0000_0000;
        endcase
      end
    end
    // Status indices have no write path at all.
    if (access && pwrite && aligned)
    begin
      case (idx)
        `SCSR_IDX_DSA:  nxt.data_structure_base  = pwdata;
        `SCSR_IDX_CTRL: nxt.ctrl = pwdata[7:0] & `SCSR_CTRL_MASK;
        default:        nxt.ctrl = r.ctrl;
      endcase
    end
    // The base is saved when a memory move starts and put back when it ends,
    // so anything written to it meanwhile does not survive the move.
    nxt.move_d = mm_move;
    if (mm_move && !r.move_d)
      nxt.dsa_shadow = r.data_structure_base;
    if (!mm_move && r.move_d)
      nxt.data_structure_base = r.dsa_shadow;
    nxt.req_d = scsi_req;
    if (scsi_req && !r.req_d)
      nxt.phase = {scsi_msg, scsi_cd, scsi_io};
    if (arb.st == ARB_WON || selected_in)
      nxt.connected_flag = 1'b1;
    else if (bus_free)
      nxt.connected_flag = 1'b0;
    if (!r.connected_flag)
      nxt.last_disconnect = 1'b1;
    else if (block_move)
      nxt.last_disconnect = 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      r      <= '0;
      r.ctrl <= `SCSR_CTRL_RST;
      r.data_structure_base  <= `SCSR_DSA_RST;
      r.last_disconnect <= `SCSR_LAST_DISCONNECT_RST;
    end
    else
      r <= nxt;

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata    = r.prdata;
  assign pready    = r.pready;
  assign pslverr   = r.pslverr;
  assign bsy_drive = arb.drive;
  assign connected = r.connected_flag;
  assign dsa_out   = r.data_structure_base;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence rd_setup(logic [5:0] i);
    psel && !penable && !pwrite && paddr == {i, 2'b00};
  endsequence

  sequence wr_status;
    access && pwrite && aligned &&
    (idx == `SCSR_IDX_STAT_ARB || idx == `SCSR_IDX_STAT_FIFO ||
     idx == `SCSR_IDX_STAT_UPPER);
  endsequence

  apb_answer_a: assert property (setup |=> pready ##1 !pready || (psel && !penable))
    else $error("access phase answer not given in one cycle");
  rst_status_a: assert property (rd_setup(`SCSR_IDX_STAT_ARB) |=>
      prdata[1] == ($past(scsi_rst) | $past(r.ctrl[`SCSR_CTRL_SW_RST])))
    else $error("reset status bit wrong");
  live_par_lo_a: assert property (rd_setup(`SCSR_IDX_STAT_ARB) |=>
      prdata[0] == $past(scsi_sdp_lo))
    else $error("live low parity bit wrong");
  fifo_low_a: assert property (rd_setup(`SCSR_IDX_STAT_FIFO) |=>
      prdata[7:4] == $past(fifo_count[3:0]))
    else $error("fifo count low bits wrong");
  upper_live_a: assert property (rd_setup(`SCSR_IDX_STAT_UPPER) |=>
      prdata[4] == $past(fifo_count[4]) && prdata[2] == $past(differential_sense_pin) &&
      prdata[0] == $past(scsi_sdp_hi))
    else $error("upper status live bits wrong");
  phase_catch_a: assert property (scsi_req && !r.req_d |=>
      r.phase == {$past(scsi_msg), $past(scsi_cd), $past(scsi_io)})
    else $error("phase bits not captured on REQ");
  last_disconnect_set_a: assert property (!r.connected_flag |=> r.last_disconnect)
    else $error("last disconnect not set while unconnected");
  last_disconnect_clear_a: assert property (r.connected_flag && block_move |=> !r.last_disconnect)
    else $error("last disconnect not cleared by block move");
  con_drop_a: assert property (bus_free && !selected_in && arb.st != ARB_WON |=> !r.connected_flag)
    else $error("connected flag held on free bus");
  dsa_restore_a: assert property (!mm_move && r.move_d |=> r.data_structure_base == $past(r.dsa_shadow))
    else $error("base not restored after memory move");
  ro_status_a: assert property (wr_status ##0 !mm_move && !r.move_d |=>
      $stable(r.ctrl) && $stable(r.data_structure_base) && $stable(r.phase))
    else $error("status write altered state");
endmodule // scsr_top
